// *** sscl_regs.vh ***
// Purpose : constants for the start and stop command block
// Assumes : included by the register slave, the command interpreter and the bench
// Notes   : register offsets are byte addresses on a 32-bit classic bus
`ifndef SSCL_REGS_VH
`define SSCL_REGS_VH

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define SSCL_CTRL_OFS      8'h00   // control options
`define SSCL_DINSEL_OFS    8'h04   // digital input function codes
`define SSCL_CMD_OFS       8'h08   // network command word
`define SSCL_STAT_OFS      8'h0C   // drive state, read only
`define SSCL_ZSPD_OFS      8'h10   // deceleration step

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define SSCL_THREE_WIRE_BIT 8      // control options: momentary mode
`define SSCL_CMD_STOP_BIT   0      // command word: ramp stop
`define SSCL_CMD_START_BIT  1      // command word: start / run
`define SSCL_CMD_TLIM_BIT   8      // command word: current-limit halt
`define SSCL_CMD_COAST_BIT  9      // command word: coast halt

// ------------------------------------------------------------
// digital input function codes
// ------------------------------------------------------------
`define SSCL_FN_STOP_CF    5'h04   // ramp stop plus fault clear
`define SSCL_FN_START      5'h05   // momentary start
`define SSCL_FN_RUN        5'h07   // maintained run
`define SSCL_FN_STOP       5'h0E   // plain ramp stop
`define SSCL_FN_TLIM       5'h12   // current-limit stop
`define SSCL_FN_COAST      5'h13   // coast stop

// ------------------------------------------------------------
// reset values and full-scale speed
// ------------------------------------------------------------
`define SSCL_CTRL_RST      32'h00000100
`define SSCL_DECEL_RST     16'h0010
`define SSCL_SPD_MAX       16'hFFFF

// ------------------------------------------------------------
// drive states
// ------------------------------------------------------------
`define SSCL_ST_IDLE       3'h0
`define SSCL_ST_RUN        3'h1
`define SSCL_ST_RAMP       3'h2
`define SSCL_ST_TLIM       3'h3

`endif

// *** sscl_sync_edge.v ***
// Purpose : two-flop synchroniser with rising-edge pulse per bit
// Assumes : inputs come from outside the clock domain
// Notes   : first flop feeds only the second flop
`default_nettype none

module sscl_sync_edge #(
   parameter W = 6
) (
   // clock and control
   input  wire         clk_i,
   input  wire         rst_i,
   input  wire         ce_i,
   // async inputs
   input  wire [W-1:0] async_i,
   // synchronised level and rising edge
   output wire [W-1:0] level_o,
   output wire [W-1:0] rise_o
);

   reg [W-1:0] meta_reg;   // first stage, read by second only
   reg [W-1:0] sync_reg;   // second stage, safe to use
   reg [W-1:0] prev_reg;   // delayed copy for edge detect

   // ------------------------------------------------------------
   // synchroniser stages
   // ------------------------------------------------------------
   always @(posedge clk_i) begin
      if (rst_i) begin
         meta_reg <= {W{1'b0}};
         sync_reg <= {W{1'b0}};
         prev_reg <= {W{1'b0}};
      end else if (ce_i) begin
         meta_reg <= async_i;
         sync_reg <= meta_reg;
         prev_reg <= sync_reg;
      end
   end

   assign level_o = sync_reg;
   assign rise_o  = sync_reg & ~prev_reg;   // one pulse per held level

endmodule // sscl_sync_edge
`default_nettype wire

// *** sscl_wb_regs.v ***
// Purpose : classic wishbone slave holding the block's registers
// Assumes : single-cycle classic transfers, 32-bit data
// Notes   : ack one cycle after the request, dropped next cycle
`default_nettype none
`include "sscl_regs.vh"

module sscl_wb_regs #(
   parameter NDI = 6
) (
   // clock and control
   input  wire             clk_i,
   input  wire             rst_i,
   input  wire             ce_i,
   // wishbone slave
   input  wire             wb_cyc_i,
   input  wire             wb_stb_i,
   input  wire             wb_we_i,
   input  wire [7:0]       wb_adr_i,
   input  wire [3:0]       wb_sel_i,
   input  wire [31:0]      wb_dat_i,
   output reg  [31:0]      wb_dat_o,
   output reg              wb_ack_o,
   output reg              wb_err_o,
   // register contents
   output reg  [31:0]      ctrl_o,
   output reg  [5*NDI-1:0] dinsel_o,
   output reg  [31:0]      cmd_o,
   output reg  [15:0]      decel_o,
   // state to read
   input  wire [31:0]      stat_i
);

   wire req      = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;  // new request
   wire hit_ctrl = (wb_adr_i == `SSCL_CTRL_OFS);
   wire hit_dsel = (wb_adr_i == `SSCL_DINSEL_OFS);
   wire hit_cmd  = (wb_adr_i == `SSCL_CMD_OFS);
   wire hit_stat = (wb_adr_i == `SSCL_STAT_OFS);
   wire hit_dec  = (wb_adr_i == `SSCL_ZSPD_OFS);
   wire hit_any  = hit_ctrl | hit_dsel | hit_cmd | hit_stat | hit_dec;

   // byte-lane merge of write data into an old word
   function [31:0] merge;
      input [31:0] old;
      input [31:0] nw;
      input [3:0]  sel;
      integer k;
      begin
         merge = old;
         for (k = 0; k < 4; k = k + 1) begin
            if (sel[k]) merge[8*k +: 8] = nw[8*k +: 8];
         end
      end
   endfunction

   wire [31:0] dsel_pad = {{(32-5*NDI){1'b0}}, dinsel_o};
   wire [31:0] dsel_new = merge(dsel_pad, wb_dat_i, wb_sel_i);
   wire [31:0] dec_new  = merge({16'h0000, decel_o}, wb_dat_i, wb_sel_i);

   // ------------------------------------------------------------
   // decode, write and read
   // ------------------------------------------------------------
   always @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_o   <= `SSCL_CTRL_RST;
         dinsel_o <= {(5*NDI){1'b0}};
         cmd_o    <= 32'h00000000;
         decel_o  <= `SSCL_DECEL_RST;
         wb_dat_o <= 32'h00000000;
         wb_ack_o <= 1'b0;
         wb_err_o <= 1'b0;
      end else if (ce_i) begin
         wb_ack_o <= req & hit_any;
         wb_err_o <= req & ~hit_any;    // unmapped address answers err
         if (req & wb_we_i) begin
            if (hit_ctrl) ctrl_o   <= merge(ctrl_o, wb_dat_i, wb_sel_i);
            if (hit_dsel) dinsel_o <= dsel_new[5*NDI-1:0];
            if (hit_cmd)  cmd_o    <= merge(cmd_o, wb_dat_i, wb_sel_i);
            if (hit_dec)  decel_o  <= dec_new[15:0];
         end
         if (req & ~wb_we_i) begin
            case (1'b1)
               hit_ctrl: wb_dat_o <= ctrl_o;
               hit_dsel: wb_dat_o <= dsel_pad;
               hit_cmd:  wb_dat_o <= cmd_o;
               hit_stat: wb_dat_o <= stat_i;
               hit_dec:  wb_dat_o <= {16'h0000, decel_o};
               default:  wb_dat_o <= 32'h00000000;
            endcase
         end
      end
   end

endmodule // sscl_wb_regs
`default_nettype wire

// *** sscl_start_stop.v ***
// Purpose : start and stop command interpreter for a motor drive
// Assumes : one clock, synchronous reset, registers over classic wishbone
// Notes   : digital inputs and keypad keys are asynchronous and synchronised
//           speed reference jumps to full scale on a start;
//           acceleration shaping is left to the speed loop
`default_nettype none
`include "sscl_regs.vh"

module sscl_start_stop #(
   parameter NDI = 6                       // number of digital inputs
) (
   // clock, reset, enable
   input  wire         clk_i,
   input  wire         rst_i,
   input  wire         ce_i,
   // wishbone slave
   input  wire         wb_cyc_i,
   input  wire         wb_stb_i,
   input  wire         wb_we_i,
   input  wire [7:0]   wb_adr_i,
   input  wire [3:0]   wb_sel_i,
   input  wire [31:0]  wb_dat_i,
   output wire [31:0]  wb_dat_o,
   output wire         wb_ack_o,
   output wire         wb_err_o,
   // digital inputs and keypad keys (asynchronous)
   input  wire [NDI-1:0] dig_in_i,
   input  wire         key_start_i,
   input  wire         key_stop_i,
   // drive outputs
   output reg          run_o,             // output stage enabled
   output reg  [15:0]  speed_ref_o,       // speed reference, ramped only in a ramp stop
   output reg  [2:0]   stop_kind_o,       // active stop: coast, tlim, ramp
   output reg          fault_clear_o      // one-cycle fault clear pulse
);

   // ------------------------------------------------------------
   // registers and synchronisers
   // ------------------------------------------------------------
   wire [31:0]      ctrl;                 // control options
   wire [5*NDI-1:0] dinsel;               // 5-bit code per input
   wire [31:0]      cmd;                  // network command word
   wire [15:0]      decel;                // speed step per cycle
   wire [31:0]      stat;                 // state readback
   wire [NDI+1:0]   lvl;                  // synchronised levels
   wire [NDI+1:0]   rise;                 // rising edges

   // control, input codes, command word and ramp step;
   // each request answered one cycle later
   sscl_wb_regs #(.NDI(NDI)) u_regs (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .ce_i     (ce_i),
      .wb_cyc_i (wb_cyc_i),
      .wb_stb_i (wb_stb_i),
      .wb_we_i  (wb_we_i),
      .wb_adr_i (wb_adr_i),
      .wb_sel_i (wb_sel_i),
      .wb_dat_i (wb_dat_i),
      .wb_dat_o (wb_dat_o),
      .wb_ack_o (wb_ack_o),
      .wb_err_o (wb_err_o),
      .ctrl_o   (ctrl),
      .dinsel_o (dinsel),
      .cmd_o    (cmd),
      .decel_o  (decel),
      .stat_i   (stat)
   );

   // pins cross in through two flops before any logic sees them
   sscl_sync_edge #(.W(NDI+2)) u_sync (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .ce_i    (ce_i),
      .async_i ({key_stop_i, key_start_i, dig_in_i}),
      .level_o (lvl),
      .rise_o  (rise)
   );

   // mode bit: 1 momentary starts and stops,
   // 0 one maintained run level
   wire three_wire_select = ctrl[`SSCL_THREE_WIRE_BIT];

   // ------------------------------------------------------------
   // digital input decode, one slice per input
   // ------------------------------------------------------------
   wire [NDI-1:0] di_stop_cf;             // stop with fault clear, edge
   wire [NDI-1:0] di_stop;                // plain ramp stop, edge
   wire [NDI-1:0] di_start;               // momentary start, edge
   wire [NDI-1:0] di_run;                 // maintained run, level
   wire [NDI-1:0] di_coast;               // coast stop, edge
   wire [NDI-1:0] di_tlim;                // current-limit stop, edge

   // each input owns a 5-bit function code;
   // an unused code has no effect on the drive
   // stops act on edges, so a held stop input
   // only blocks a start in its own edge cycle
   genvar g;
   generate
      for (g = 0; g < NDI; g = g + 1) begin : g_di
         wire [4:0] fn = dinsel[5*g +: 5];
         assign di_stop_cf[g] = rise[g] & (fn == `SSCL_FN_STOP_CF);
         assign di_stop[g]    = rise[g] & (fn == `SSCL_FN_STOP);
         assign di_start[g]   = rise[g] & (fn == `SSCL_FN_START);
         assign di_run[g]     = lvl[g]  & (fn == `SSCL_FN_RUN);
         assign di_coast[g]   = rise[g] & (fn == `SSCL_FN_COAST);
         assign di_tlim[g]    = rise[g] & (fn == `SSCL_FN_TLIM);
      end
   endgenerate

   // ------------------------------------------------------------
   // command word edge detection
   // ------------------------------------------------------------
   reg [3:0] cmd_prev_reg;                // last sampled command bits
   wire [3:0] cmd_now = {cmd[`SSCL_CMD_COAST_BIT], cmd[`SSCL_CMD_TLIM_BIT],
                         cmd[`SSCL_CMD_START_BIT], cmd[`SSCL_CMD_STOP_BIT]};
   wire [3:0] cmd_rise = cmd_now & ~cmd_prev_reg;

   // last command bits; reset value matches the
   // cleared command word, so no false edge
   always @(posedge clk_i) begin
      if (rst_i)
         cmd_prev_reg <= 4'h0;
      else if (ce_i)
         cmd_prev_reg <= cmd_now;
   end

   // named views of the edges and levels used below
   wire net_stop_p  = cmd_rise[0];
   wire net_start_p = cmd_rise[1];
   wire net_tlim_p  = cmd_rise[2];
   wire net_coast_p = cmd_rise[3];
   wire net_run_lvl = cmd_now[1];
   wire key_start_p = rise[NDI];
   wire key_stop_p  = rise[NDI+1];

   // ------------------------------------------------------------
   // request gathering per mode
   // ------------------------------------------------------------
   // an edge counts once: a held command bit cannot restart after a network halt
   wire coast_req = |di_coast | net_coast_p;
   wire tlim_req  = |di_tlim  | net_tlim_p;
   wire clr_req   = |di_stop_cf;
   reg  ramp_req;                                            // any ramp stop
   reg  start_req;                                           // momentary start
   reg  run_lvl;                                             // maintained run

   // network halts in maintained mode latch until bit 1 re-rises
   reg net_block_reg;

   // gather what the mode allows: coast and
   // current-limit are mode free, ramp and
   // start depend on the mode bit
   always @* begin
      ramp_req  = |di_stop | |di_stop_cf;
      start_req = 1'b0;
      run_lvl   = 1'b0;
      if (three_wire_select) begin
         // momentary: keypad stop always ramps
         ramp_req  = ramp_req | net_stop_p | key_stop_p;
         start_req = |di_start | net_start_p | key_start_p;
      end else begin
         // maintained: keypad start has no effect here
         run_lvl = |di_run | (net_run_lvl & ~net_block_reg);
         ramp_req = ramp_req | key_stop_p;
      end
   end

   // block flag: a network halt in maintained mode
   // keeps the held run bit from restarting;
   // set wins when a halt and a fresh edge meet
   always @(posedge clk_i) begin
      if (rst_i)
         net_block_reg <= 1'b0;
      else if (ce_i) begin
         if (!three_wire_select && (net_coast_p || net_tlim_p))
            net_block_reg <= 1'b1;
         else if (net_start_p)
            net_block_reg <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // drive state machine
   // ------------------------------------------------------------
   // idle with output stage off, run at full
   // reference, ramp down, current-limit halt
   localparam ST_IDLE = `SSCL_ST_IDLE;
   localparam ST_RUN  = `SSCL_ST_RUN;
   localparam ST_RAMP = `SSCL_ST_RAMP;
   localparam ST_TLIM = `SSCL_ST_TLIM;

   reg [2:0]  state_reg;                  // current drive state
   reg [2:0]  state_next;
   reg [15:0] spd_next;
   reg        run_was_reg;                // maintained level last cycle

   // a maintained run level that drops ramps
   wire maint_fall = ~three_wire_select & run_was_reg & ~run_lvl;

   // ramp step from the register, once per cycle
   // deceleration clamped at zero
   wire [15:0] spd_dec  = (speed_ref_o > decel) ? (speed_ref_o - decel) : 16'h0000;
   // current-limit stop drops the reference straight to zero
   wire        go_run   = three_wire_select ? start_req : run_lvl;

   // next state and reference; the order of the
   // tests is the stop priority: coast over
   // current limit over ramp
   // a start in the same cycle as any stop is
   // dropped, the safer reading of a collision
   always @* begin
      state_next = state_reg;
      spd_next   = speed_ref_o;
      case (state_reg)
         ST_IDLE: begin
            // start only from rest, with no stop pending
            if (go_run && !coast_req && !tlim_req && !ramp_req) begin
               state_next = ST_RUN;
               spd_next   = `SSCL_SPD_MAX;
            end
         end
         // a stronger stop cuts any active state short
         ST_RUN, ST_RAMP, ST_TLIM: begin
            if (coast_req) begin
               state_next = ST_IDLE;
               spd_next   = 16'h0000;
            end else if (tlim_req || state_reg == ST_TLIM) begin
               state_next = ST_TLIM;
               spd_next   = 16'h0000;
               // reference already zero: off next cycle
               if (state_reg == ST_TLIM)
                  state_next = ST_IDLE;
            end else if (ramp_req || maint_fall || state_reg == ST_RAMP) begin
               state_next = ST_RAMP;
               spd_next   = spd_dec;
               // reference reached zero: stage off
               if (spd_dec == 16'h0000)
                  state_next = ST_IDLE;
            end
         end
         default: begin
            state_next = ST_IDLE;
            spd_next   = 16'h0000;
         end
      endcase
   end

   // ------------------------------------------------------------
   // state and output registers
   // ------------------------------------------------------------
   // outputs straight from flip-flops; run_o follows
   // the next state, so it drops as the stop ends
   // a low clock enable holds every register,
   // synchronisers and bus slave included
   always @(posedge clk_i) begin
      if (rst_i) begin
         state_reg     <= ST_IDLE;
         speed_ref_o   <= 16'h0000;
         run_o         <= 1'b0;
         stop_kind_o   <= 3'h0;
         fault_clear_o <= 1'b0;
         run_was_reg   <= 1'b0;
      end else if (ce_i) begin
         state_reg     <= state_next;
         speed_ref_o   <= spd_next;
         run_o         <= (state_next != ST_IDLE);
         stop_kind_o   <= {state_next == ST_IDLE && coast_req,
                           state_next == ST_TLIM,
                           state_next == ST_RAMP};
         fault_clear_o <= clr_req;
         run_was_reg   <= run_lvl;
      end
   end

   // readback: state, run, mode, block flag and
   // the upper speed byte, enough to watch a ramp
   // without widening the word
   assign stat = {16'h0000, speed_ref_o[15:8], 2'b00, net_block_reg,
                  three_wire_select, run_o, state_reg};

endmodule // sscl_start_stop
`default_nettype wire

// *** sscl_far_side.sv ***
// Purpose: far-side model for the pins and keypad keys of the block
// Assumes: bench asks for pin levels right after a rising edge
// Notes  : levels change only after a clock edge, like a slow field device
`default_nettype none
module sscl_far_side (
   // clock
   input  wire logic       clk_i,
   // requested levels from the bench
   input  wire logic [5:0] dig_req_i,
   input  wire logic       kst_req_i,
   input  wire logic       ksp_req_i,
   // pin levels seen by the block
   output var  logic [5:0] dig_in_o = 6'h00,
   output var  logic       key_start_o = 1'b0,
   output var  logic       key_stop_o = 1'b0
);
   timeunit 1ns;
   timeprecision 1ns;
   // --------------------------------------------------
   // pin drivers: one edge of lag, full levels held
   // --------------------------------------------------
   always @(posedge clk_i) begin
      dig_in_o    <= dig_req_i;
      key_start_o <= kst_req_i;
      key_stop_o  <= ksp_req_i;
   end
endmodule // sscl_far_side
`default_nettype wire

// *** sscl_start_stop_chk.sv ***
// Purpose: port-level checks for the start and stop block
// Assumes: bound onto the top module, one clock domain
// Notes  : stop kinds are coast bit2, current-limit bit1, ramp bit0
`default_nettype none
module sscl_start_stop_chk (
   // clock and reset
   input wire logic        clk_i,
   input wire logic        rst_i,
   // bus handshake
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_ack_o,
   // drive outputs
   input wire logic        run_o,
   input wire logic [15:0] speed_ref_o,
   input wire logic [2:0]  stop_kind_o,
   input wire logic        fault_clear_o
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // --------------------------------------------------
   // stop, run, fault clear and bus behaviour
   // --------------------------------------------------
   chk_coast_off: assert property (stop_kind_o[2] |-> ##[0:1] !run_o)
      else $error("coast stop left output stage on");
   chk_coast_first: assert property (stop_kind_o[2] |-> stop_kind_o[1:0] == 2'b00)
      else $error("lower stop kind active beside coast");
   chk_tlim_zero: assert property ($rose(stop_kind_o[1]) |-> ##[0:2] speed_ref_o == 16'h0000)
      else $error("current-limit stop kept speed reference");
   chk_tlim_off: assert property (stop_kind_o[1] && speed_ref_o == 16'h0000 |-> ##[0:2] !run_o)
      else $error("current-limit stop kept output stage on");
   chk_ramp_down: assert property (run_o && stop_kind_o == 3'b001 |=> speed_ref_o <= $past(speed_ref_o))
      else $error("ramp raised speed reference");
   chk_ramp_keep: assert property (stop_kind_o == 3'b001 && speed_ref_o != 16'h0000 |-> run_o)
      else $error("ramp dropped output stage early");
   chk_run_full: assert property ($rose(run_o) |-> ##[0:1] speed_ref_o == 16'hFFFF)
      else $error("run without full speed reference");
   chk_fclr_pulse: assert property (fault_clear_o |=> !fault_clear_o)
      else $error("fault clear longer than one cycle");
   chk_ack_req: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i) ##1 !wb_ack_o)
      else $error("bus ack without request or too long");
endmodule // sscl_start_stop_chk
`default_nettype wire

// *** sscl_start_stop_tb.sv ***
// Purpose: self-checking bench for the start and stop block
// Assumes: bus answers are checked by a monitor from a queue
// Notes  : random ramp steps keep every stop short
`default_nettype none
`include "sscl_regs.vh"
module sscl_start_stop_tb;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {logic err; logic [31:0] dat; logic [31:0] msk;} sscl_exp_t;
   logic        clk_i = 0, rst_i = 1, ce_i = 1;
   logic        wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o, wb_err_o;
   logic [7:0]  wb_adr_i = 8'h00;
   logic [3:0]  wb_sel_i = 4'hF;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, d;
   logic [5:0]  dig_req = 6'h00, dig_in;
   logic        kst_req = 0, ksp_req = 0, key_start, key_stop, run_o, fault_clear_o, seen_clr = 0;
   logic [15:0] speed_ref_o;
   logic [2:0]  stop_kind_o;
   logic [3:0]  seen = 4'h0;          // sticky stop kinds and fault clear
   sscl_exp_t   expq[$];              // expected bus answers, oldest first
   int          mismatches = 0, total_checks = 0, cyc = 0, seed, k;
   // --------------------------------------------------
   // clock, timeout, instances
   // --------------------------------------------------
   initial forever #50 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      seen <= seen_clr ? 4'h0 : (seen | {fault_clear_o, stop_kind_o});
      if (cyc == 20000) begin
         mismatches++;
         stop_test();
      end
   end
   sscl_far_side far (.clk_i(clk_i), .dig_req_i(dig_req), .kst_req_i(kst_req), .ksp_req_i(ksp_req),
      .dig_in_o(dig_in), .key_start_o(key_start), .key_stop_o(key_stop));
   sscl_start_stop #(.NDI(6)) dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
      .dig_in_i(dig_in), .key_start_i(key_start), .key_stop_i(key_stop), .run_o(run_o),
      .speed_ref_o(speed_ref_o), .stop_kind_o(stop_kind_o), .fault_clear_o(fault_clear_o));
   // --------------------------------------------------
   // shared tasks
   // --------------------------------------------------
   task automatic check(input logic [31:0] seen_v, input logic [31:0] exp_v);
      total_checks++;
      if (seen_v !== exp_v) begin
         mismatches++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen_v, exp_v);
      end
   endtask
   task automatic stop_test();
      $display("checks=%0d mismatches=%0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // one classic cycle; held until ack or err is sampled high
   task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                      input logic [31:0] ex, input logic [31:0] msk, input logic er);
      expq.push_back('{er, ex, msk});
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= adr;
      wb_dat_i <= wd;
      do @(posedge clk_i); while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic wait_run(input logic v);
      for (int i = 0; i < 300 && run_o !== v; i++) @(posedge clk_i);
      check({31'h0, run_o}, {31'h0, v});
   endtask
   task automatic pulse(input int p);
      if (p < 6) dig_req[p] <= 1'b1;
      else if (p == 6) ksp_req <= 1'b1;
      else kst_req <= 1'b1;
      repeat (5) @(posedge clk_i);
      dig_req <= 6'h00;
      ksp_req <= 1'b0;
      kst_req <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic clr_seen();
      seen_clr <= 1'b1;
      @(posedge clk_i);
      seen_clr <= 1'b0;
      @(posedge clk_i);
   endtask
   // --------------------------------------------------
   // monitor: oldest note against each bus answer
   // --------------------------------------------------
   always @(posedge clk_i) begin
      if (wb_ack_o === 1'b1 || wb_err_o === 1'b1) begin
         check({31'h0, wb_err_o}, {31'h0, expq[0].err});
         check(wb_dat_o & expq[0].msk, expq[0].dat & expq[0].msk);
         void'(expq.pop_front());
      end
   end
   // --------------------------------------------------
   // main sequence
   // --------------------------------------------------
   initial begin
      seed = 77392;
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      bus(0, `SSCL_CTRL_OFS, 0, 32'h100, 32'hFFFFFFFF, 0);
      bus(0, `SSCL_ZSPD_OFS, 0, 32'h10, 32'hFFFFFFFF, 0);
      bus(1, `SSCL_STAT_OFS, 32'hFFFFFFFF, 0, 0, 0);
      bus(0, `SSCL_STAT_OFS, 0, 32'h10, 32'hFFDF, 0);
      bus(0, 8'h14, 0, 0, 0, 1);
      d = $random(seed);
      bus(1, `SSCL_ZSPD_OFS, {19'h0, 1'b1, d[11:0]}, 0, 0, 0);
      bus(1, `SSCL_DINSEL_OFS, {2'b00, `SSCL_FN_RUN, `SSCL_FN_TLIM, `SSCL_FN_COAST,
          `SSCL_FN_STOP, `SSCL_FN_STOP_CF, `SSCL_FN_START}, 0, 0, 0);
      // network pulses: ramp, current limit, coast, all three at once
      for (k = 0; k < 4; k++) begin
         d = (k == 0) ? 32'h1 : (k == 1) ? 32'h100 : (k == 2) ? 32'h200 : 32'h301;
         bus(1, `SSCL_CMD_OFS, 32'h2, 0, 0, 0);
         bus(1, `SSCL_CMD_OFS, 32'h0, 0, 0, 0);
         wait_run(1);
         bus(0, `SSCL_STAT_OFS, 0, 32'hFF19, 32'hFF1F, 0);
         clr_seen();
         bus(1, `SSCL_CMD_OFS, d, 0, 0, 0);
         bus(1, `SSCL_CMD_OFS, 32'h0, 0, 0, 0);
         wait_run(0);
         check(speed_ref_o, 16'h0000);
         check(seen, (k == 0) ? 4'h1 : (k == 1) ? 4'h2 : 4'h4);
      end
      // pins: start, then each stop code; keypad stop last
      for (k = 1; k <= 6; k++) begin
         if (k == 5) k = 6;
         pulse(0);
         wait_run(1);
         check(speed_ref_o, `SSCL_SPD_MAX);
         clr_seen();
         pulse(k);
         wait_run(0);
         check(seen, (k == 1) ? 4'h9 : (k == 3) ? 4'h4 : (k == 4) ? 4'h2 : 4'h1);
      end
      // maintained mode
      bus(1, `SSCL_CTRL_OFS, 32'h0, 0, 0, 0);
      bus(0, `SSCL_STAT_OFS, 0, 32'h0, 32'h1F, 0);
      pulse(7);
      repeat (10) @(posedge clk_i);
      check({31'h0, run_o}, 32'h0);
      dig_req[5] <= 1'b1;
      wait_run(1);
      ce_i <= 1'b0;
      dig_req[5] <= 1'b0;
      repeat (10) @(posedge clk_i);
      check({31'h0, run_o}, 32'h1);
      ce_i <= 1'b1;
      wait_run(0);
      bus(1, `SSCL_CMD_OFS, 32'h2, 0, 0, 0);
      wait_run(1);
      bus(1, `SSCL_CMD_OFS, 32'h202, 0, 0, 0);
      bus(1, `SSCL_CMD_OFS, 32'h2, 0, 0, 0);
      wait_run(0);
      repeat (20) @(posedge clk_i);
      check({31'h0, run_o}, 32'h0);
      bus(1, `SSCL_CMD_OFS, 32'h0, 0, 0, 0);
      bus(1, `SSCL_CMD_OFS, 32'h2, 0, 0, 0);
      wait_run(1);
      bus(1, `SSCL_CMD_OFS, 32'h0, 0, 0, 0);
      wait_run(0);
      stop_test();
   end
endmodule // sscl_start_stop_tb
bind sscl_start_stop sscl_start_stop_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .run_o(run_o), .speed_ref_o(speed_ref_o),
   .stop_kind_o(stop_kind_o), .fault_clear_o(fault_clear_o));
`default_nettype wire
